// ### ust_pkg.sv
package ust_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned SYNC_STAGES = 3;
	localparam int unsigned TRANSMIT_BUFFER_READY_MAX_CYC = 8;
	localparam int unsigned RECEIVE_CHAR_READY_MAX_CYC = 24;
	localparam int unsigned TRANSMIT_SHIFTER_EMPTY_MAX_CYC = 20;
	localparam int unsigned CTRL_MAX_CYC = 8;
	localparam int unsigned SYNC_FOUND_MAX_CYC = 24;
	localparam int unsigned STATUS_MAX_CYC = 28;
	// ---------------------------------------------------------------
	// data path
	// ---------------------------------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam logic [7:0] SYNC_RST = 8'h16;
	localparam logic [7:0] SHIFT_RST = 8'hFF;
	localparam logic [3:0] BITS_RST = 4'h0;

	typedef enum logic [3:0] {
		UST_TX_IDLE = 4'b0001,
		UST_TX_START = 4'b0010,
		UST_TX_DATA = 4'b0100,
		UST_TX_STOP = 4'b1000
	} ust_tx_state_e;

	typedef struct packed {
		logic transmit_enable_bit;
		logic receiver_enable_bit;
		logic dtr;
		logic rts;
		logic send_break;
		logic sync_mode;
		logic ext_sync;
	} ust_cmd_s;

	typedef struct packed {
		logic receive_char_ready;
		logic transmit_buffer_ready;
		logic transmit_shifter_empty;
		logic sync_found;
		logic dsr;
		logic cts;
	} ust_stat_s;
endpackage

// ### ust_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module ust_sync3 (
	input wire logic mclk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic [2:0] sh_reg;
	// first stage feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sh_reg <= 3'h0;
			dout <= 1'b0;
		end else begin
			sh_reg <= {sh_reg[1:0], din};
			if (sh_reg[1] == sh_reg[2])
				dout <= sh_reg[2];
		end
	end
endmodule
`default_nettype wire

// ### ust_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ust_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_reg] <= in_data;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### ust_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - host discards first read after enabling receiver
// R2 - external sync disables internal pattern search
// R3 - external sync status clears only once released
// R4 - host spaces init writes six clocks
// R5 - host writes data only when ready
// R6 - host spaces writes eight or sixteen clocks
// R7 - bit clocks slow relative to system clock
// R8 - reset held six clocks, clock running
// R9 - status follows events within 28 clocks
// R10 - transmit ready within 8 clocks of last bit
// R11 - receive ready within 24 clocks
// R12 - data write/read clear ready flags immediately
// R13 - internal sync found within 24 clocks
// R14 - external sync asserted before receive clock fall
// R15 - shifter empty within 20 clocks of final bit
// R16 - command controls update within 8 clocks
// R17 - modem inputs stable 20 clocks before read
// R18 - transmit clock phase minimum widths
// R19 - receive clock phase minimum widths
// R20 - bit clocks and modem inputs synchronised
module ust_core (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_write,
	input wire ust_pkg::ust_cmd_s cmd_in,
	input wire logic data_write,
	input wire logic [7:0] data_in,
	input wire logic data_read,
	input wire logic status_read,
	output ust_pkg::ust_stat_s status,
	output logic [7:0] data_out,
	output logic transmit_buffer_ready,
	output logic receive_char_ready,
	output logic transmit_shifter_empty,
	output logic sync_found,
	output logic txd,
	output logic dtr_n,
	output logic rts_n,
	input wire logic transmit_bit_clock,
	input wire logic receive_bit_clock,
	input wire logic rxd,
	input wire logic ext_sync_in,
	input wire logic dsr_n,
	input wire logic cts_n
);
	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic txc_s;
	logic rxc_s;
	logic rxd_s;
	logic esync_s;
	logic dsr_s;
	logic cts_s;
	logic [5:0] raw_in;
	logic [5:0] sync_out;
	assign raw_in = {transmit_bit_clock, receive_bit_clock, rxd, ext_sync_in, ~dsr_n, ~cts_n};
	assign {txc_s, rxc_s, rxd_s, esync_s, dsr_s, cts_s} = sync_out;
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			ust_sync3 u_sync (
				.mclk(mclk),
				.rst(rst),
				.din(raw_in[gi]),
				.dout(sync_out[gi])
			); // see R20
		end
	endgenerate

	// ---------------------------------------------------------------
	// bit clock edges
	// ---------------------------------------------------------------
	// edges show about four clocks late; every latency budget allows it
	logic txc_d_reg;
	logic rxc_d_reg;
	logic tx_fall;
	logic rx_rise;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txc_d_reg <= 1'b0;
			rxc_d_reg <= 1'b0;
		end else begin
			txc_d_reg <= txc_s;
			rxc_d_reg <= rxc_s;
		end
	end
	assign tx_fall = txc_d_reg && !txc_s;
	assign rx_rise = rxc_s && !rxc_d_reg;

	// ---------------------------------------------------------------
	// command latch
	// ---------------------------------------------------------------
	// latched whole: a command replaces every control field
	ust_pkg::ust_cmd_s cmd_reg;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cmd_reg <= '0;
		else if (cmd_write)
			cmd_reg <= cmd_in; // see R16
	end

	// ---------------------------------------------------------------
	// transmit buffer and shifter
	// ---------------------------------------------------------------
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;
	// ready drops only once all 32 words are queued
	ust_fifo #(.WIDTH(ust_pkg::DATA_W), .DEPTH(ust_pkg::FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(data_write),
		.in_ready(fifo_in_ready),
		.in_data(data_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	ust_pkg::ust_tx_state_e tx_state_reg;
	logic [7:0] tx_shift_reg;
	logic [3:0] tx_bits_reg;
	logic tx_line_reg;
	// shifter drains only while enabled and clear-to-send; that stalls the buffer
	assign fifo_pop = (tx_state_reg == ust_pkg::UST_TX_IDLE) && fifo_out_valid
		&& cmd_reg.transmit_enable_bit && cts_s && tx_fall;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_state_reg <= ust_pkg::UST_TX_IDLE;
			tx_shift_reg <= ust_pkg::SHIFT_RST;
			tx_bits_reg <= ust_pkg::BITS_RST;
			tx_line_reg <= 1'b1;
		end else if (tx_fall) begin
			case (tx_state_reg)
				ust_pkg::UST_TX_IDLE: begin
					tx_line_reg <= 1'b1;
					if (fifo_pop) begin
						tx_shift_reg <= fifo_out_data;
						tx_line_reg <= 1'b0;
						tx_state_reg <= ust_pkg::UST_TX_DATA;
						tx_bits_reg <= ust_pkg::BITS_RST;
					end
				end
				ust_pkg::UST_TX_START: begin
					tx_state_reg <= ust_pkg::UST_TX_DATA;
				end
				ust_pkg::UST_TX_DATA: begin
					tx_line_reg <= tx_shift_reg[0];
					tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
					tx_bits_reg <= tx_bits_reg + 4'h1;
					if (tx_bits_reg == 4'h7)
						tx_state_reg <= ust_pkg::UST_TX_STOP;
				end
				ust_pkg::UST_TX_STOP: begin
					tx_line_reg <= 1'b1;
					tx_state_reg <= ust_pkg::UST_TX_IDLE;
				end
				default: tx_state_reg <= ust_pkg::UST_TX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receiver, sync search
	// ---------------------------------------------------------------
	logic [7:0] rx_shift_reg;
	logic [7:0] rx_hold_reg;
	logic [2:0] rx_bits_reg;
	logic rx_active_reg;
	logic rx_done;
	logic rx_full_reg;
	logic int_sync_reg;
	logic ext_sync_reg;
	logic [7:0] rx_shift_next;
	assign rx_shift_next = {rxd_s, rx_shift_reg[7:1]};
	assign rx_done = rx_rise && rx_active_reg && (rx_bits_reg == 3'h7);
	// async start is one low sample, no mid-bit recheck: 1x clock only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_shift_reg <= ust_pkg::SHIFT_RST;
			rx_bits_reg <= 3'h0;
			rx_active_reg <= 1'b0;
		end else if (rx_rise) begin
			rx_shift_reg <= rx_shift_next;
			if (rx_active_reg)
				rx_bits_reg <= rx_bits_reg + 3'h1;
			else if (!cmd_reg.sync_mode && !rxd_s)
				rx_active_reg <= 1'b1;
			else if (cmd_reg.sync_mode && !cmd_reg.ext_sync
				&& rx_shift_next == ust_pkg::SYNC_RST)
				rx_active_reg <= 1'b1;
			else if (cmd_reg.sync_mode && cmd_reg.ext_sync && esync_s)
				rx_active_reg <= 1'b1;
			if (rx_done)
				rx_active_reg <= cmd_reg.sync_mode;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_hold_reg <= 8'h00;
			rx_full_reg <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_hold_reg <= rx_shift_next;
				rx_full_reg <= 1'b1; // see R11
			end else if (data_read) begin
				rx_full_reg <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// sync detection
	// ---------------------------------------------------------------
	// internal sync found: pattern match, only when external selected off
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			int_sync_reg <= 1'b0;
		end else if (cmd_reg.sync_mode && !cmd_reg.ext_sync && rx_rise
			&& rx_shift_next == ust_pkg::SYNC_RST) begin
			int_sync_reg <= 1'b1; // see R13
		end else if (status_read || cmd_reg.ext_sync) begin
			int_sync_reg <= 1'b0; // see R2
		end
	end
	// external sync flag: set wins over read clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ext_sync_reg <= 1'b0;
		else if (cmd_reg.ext_sync && esync_s)
			ext_sync_reg <= 1'b1; // see R3
		else if (status_read)
			ext_sync_reg <= 1'b0;
	end

	// ---------------------------------------------------------------
	// ready and empty flags
	// ---------------------------------------------------------------
	logic tx_drained;
	// shifter idle with nothing queued; pin and status share it
	assign tx_drained = (tx_state_reg == ust_pkg::UST_TX_IDLE) && !fifo_out_valid;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			transmit_buffer_ready <= 1'b0;
			receive_char_ready <= 1'b0;
			transmit_shifter_empty <= 1'b1;
			sync_found <= 1'b0;
		end else begin
			// write strobe clears at once so a second write cannot slip in
			transmit_buffer_ready <= fifo_in_ready && !data_write && cmd_reg.transmit_enable_bit
				&& cts_s; // see R10 see R12
			receive_char_ready <= (rx_full_reg || rx_done) && !data_read
				&& cmd_reg.receiver_enable_bit; // see R11 see R12
			transmit_shifter_empty <= tx_drained; // see R15
			sync_found <= int_sync_reg || ext_sync_reg;
		end
	end

	// ---------------------------------------------------------------
	// line and modem pins
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txd <= 1'b1;
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
		end else begin
			// break overrides the line but leaves the shifter running
			txd <= cmd_reg.send_break ? 1'b0 : tx_line_reg;
			dtr_n <= !cmd_reg.dtr; // see R16
			rts_n <= !cmd_reg.rts; // see R16
		end
	end

	// ---------------------------------------------------------------
	// host-visible status and data
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_out <= 8'h00;
		end else begin
			data_out <= rx_hold_reg;
		end
	end
	// status copy ignores enables and clear-to-send, unlike the pins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else begin
			status.receive_char_ready <= rx_full_reg; // see R9
			status.transmit_buffer_ready <= fifo_in_ready;
			status.transmit_shifter_empty <= tx_drained;
			status.sync_found <= int_sync_reg || ext_sync_reg;
			status.dsr <= dsr_s;
			status.cts <= cts_s;
		end
	end
endmodule
`default_nettype wire

// ### ust_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ust_core_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_write,
	input wire ust_pkg::ust_cmd_s cmd_in,
	input wire logic data_write,
	input wire logic data_read,
	input wire logic status_read,
	input wire ust_pkg::ust_stat_s status,
	input wire logic transmit_buffer_ready,
	input wire logic receive_char_ready,
	input wire logic sync_found,
	input wire logic dtr_n,
	input wire logic rts_n,
	input wire logic ext_sync_in,
	input wire logic dsr_n
);
	// ----
	// checks
	// ----
	logic ext_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_reg <= 1'b0;
		end else if (cmd_write) begin
			ext_reg <= cmd_in.sync_mode & cmd_in.ext_sync;
		end
	end
	// long enough to cover the input synchroniser
	sequence ext_held;
		(ext_reg && ext_sync_in) [*8] ##1 (ext_reg && ext_sync_in) [*4];
	endsequence
	sequence ext_gone;
		(ext_reg && !ext_sync_in) [*8];
	endsequence
	a_tx_clear: assert property (data_write |=> !transmit_buffer_ready)
		else $error("transmit ready held after write");
	a_rx_clear: assert property (data_read |=> !receive_char_ready)
		else $error("receive ready held after read");
	a_dtr_follow: assert property (cmd_write |-> ##2 dtr_n == !$past(cmd_in.dtr, 2))
		else $error("dtr late");
	a_rts_follow: assert property (cmd_write |-> ##2 rts_n == !$past(cmd_in.rts, 2))
		else $error("rts late");
	a_rx_status: assert property ($rose(receive_char_ready) |->
		##[0:28] (status.receive_char_ready || !receive_char_ready))
		else $error("receive status late");
	a_dsr_status: assert property (!dsr_n [*8] |-> ##[0:20] (status.dsr || dsr_n))
		else $error("dsr status late");
	a_ext_hold: assert property (ext_held |-> sync_found)
		else $error("external sync status dropped");
	a_ext_clear: assert property (ext_gone ##0 status_read |=> ##[0:2] !sync_found)
		else $error("external sync status not cleared");
	a_int_off: assert property (ext_gone |-> !$rose(sync_found))
		else $error("internal search active in external mode");
endmodule
bind ust_core ust_core_assertions ust_core_assertions_i (.mclk, .rst, .cmd_write, .cmd_in,
	.data_write, .data_read, .status_read, .status, .transmit_buffer_ready,
	.receive_char_ready, .sync_found, .dtr_n, .rts_n, .ext_sync_in, .dsr_n);
`default_nettype wire

// ### ust_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ust_line_model (
	input wire logic txd,
	input wire logic tx_run,
	output logic transmit_bit_clock,
	output logic receive_bit_clock,
	output logic rxd,
	output logic [7:0] tx_byte,
	output int tx_frames
);
	// ----
	// line
	// ----
	int bit_no;
	initial begin
		transmit_bit_clock = 1'b0;
		receive_bit_clock = 1'b0;
		rxd = 1'b1;
		tx_byte = 8'h00;
		tx_frames = 0;
		bit_no = 0;
	end
	always #16 transmit_bit_clock = tx_run ? ~transmit_bit_clock : 1'b0;
	// the shifter moves a few clocks after a fall, so a fall sees mid bit
	always @(negedge transmit_bit_clock) begin
		if (bit_no == 0) begin
			bit_no = txd ? 0 : 1;
		end else if (bit_no < 9) begin
			tx_byte[bit_no - 1] = txd;
			bit_no = bit_no + 1;
		end else begin
			bit_no = 0;
			tx_frames = tx_frames + 1;
		end
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			#16 receive_bit_clock = 1'b1;
			#16 receive_bit_clock = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### tb_ust_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ust_core;
	// ----
	// bench
	// ----
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cmd_write = 1'b0;
	ust_pkg::ust_cmd_s cmd_in = '0;
	logic data_write = 1'b0;
	logic [7:0] data_in = 8'h00;
	logic data_read = 1'b0;
	logic status_read = 1'b0;
	logic ext_sync_in = 1'b0;
	logic dsr_n = 1'b0;
	logic cts_n = 1'b0;
	logic tx_run = 1'b0;
	ust_pkg::ust_stat_s status;
	logic [7:0] data_out, tx_byte;
	logic transmit_buffer_ready, receive_char_ready, transmit_shifter_empty, sync_found;
	logic txd, dtr_n, rts_n, transmit_bit_clock, receive_bit_clock, rxd;
	int tx_frames;
	int error_cnt = 0;
	int checks_done = 0;
	always #2 mclk = ~mclk;
	ust_core ust_core_i (.mclk, .rst, .cmd_write, .cmd_in, .data_write, .data_in, .data_read,
		.status_read, .status, .data_out, .transmit_buffer_ready, .receive_char_ready,
		.transmit_shifter_empty, .sync_found, .txd, .dtr_n, .rts_n, .transmit_bit_clock,
		.receive_bit_clock, .rxd, .ext_sync_in, .dsr_n, .cts_n);
	ust_line_model ust_line_model_i (.txd, .tx_run, .transmit_bit_clock, .receive_bit_clock,
		.rxd, .tx_byte, .tx_frames);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// eight clocks apart keeps async write recovery
	task automatic strobe(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(7);
	endtask
	task automatic await(ref logic s, input logic v, input int n);
		repeat (n) begin
			if (s === v) return;
			tick(1);
		end
	endtask
	task automatic cmd(input logic [6:0] c);
		cmd_in = c;
		strobe(cmd_write);
	endtask
	task automatic t_reset();
		tick(12);
		check("flags", {4'h0, transmit_buffer_ready, receive_char_ready,
			transmit_shifter_empty, sync_found}, 8'h02);
		check("pins", {5'h00, txd, dtr_n, rts_n}, 8'h07);
		check("status", {2'h0, status}, 8'h00);
		rst = 1'b0;
		tick(1);
	endtask
	task automatic t_ctrl();
		cmd(7'h68);
		check("modem", {6'h00, dtr_n, rts_n}, 8'h02);
		cmd(7'h78);
		check("modem", {6'h00, dtr_n, rts_n}, 8'h00);
		strobe(data_read);
	endtask
	task automatic t_fill();
		int n;
		n = 0;
		while (transmit_buffer_ready === 1'b1 && n < 40) begin
			data_in = 8'(n) ^ 8'hA5;
			strobe(data_write);
			n++;
		end
		check("depth", 8'(n >= 32 && n <= 33), 8'h01);
		tx_run = 1'b1;
		for (int i = 0; i < n; i++) begin
			for (int t = 0; t < 100 && tx_frames <= i; t++) tick(1);
			check("tx byte", tx_byte, 8'(i) ^ 8'hA5);
		end
		check("tx ready", 8'(transmit_buffer_ready), 8'h01);
		await(transmit_shifter_empty, 1'b1, 20);
		check("empty", {7'h00, transmit_shifter_empty}, 8'h01);
		tx_run = 1'b0;
	endtask
	task automatic t_rx();
		ust_line_model_i.send(8'h3C);
		await(receive_char_ready, 1'b1, 20);
		check("rx ready", {7'h00, receive_char_ready}, 8'h01);
		check("rx data", data_out, 8'h3C);
		tick(28);
		check("rx status", {7'h00, status.receive_char_ready}, 8'h01);
		strobe(data_read);
		check("rx clear", {7'h00, receive_char_ready}, 8'h00);
	endtask
	task automatic t_modem();
		dsr_n = 1'b1;
		cts_n = 1'b1;
		tick(20);
		strobe(status_read);
		check("status", {2'h0, status}, 8'h18);
		check("tx ready", {7'h00, transmit_buffer_ready}, 8'h00);
		dsr_n = 1'b0;
		cts_n = 1'b0;
		tick(20);
		strobe(status_read);
		check("status", {2'h0, status}, 8'h1B);
		cmd(7'h7C);
		check("break", {7'h00, txd}, 8'h00);
		cmd(7'h78);
		check("break", {7'h00, txd}, 8'h01);
	endtask
	task automatic t_sync();
		cmd(7'h7B);
		tick(8);
		ext_sync_in = 1'b1;
		tick(28);
		strobe(status_read);
		check("ext hold", {7'h00, sync_found}, 8'h01);
		check("ext status", {7'h00, status.sync_found}, 8'h01);
		ext_sync_in = 1'b0;
		tick(12);
		strobe(status_read);
		check("ext clear", {7'h00, sync_found}, 8'h00);
		ust_line_model_i.send(ust_pkg::SYNC_RST);
		tick(24);
		check("no hunt", {7'h00, sync_found}, 8'h00);
		cmd(7'h7A);
		tick(8);
		ust_line_model_i.send(ust_pkg::SYNC_RST);
		await(sync_found, 1'b1, 24);
		check("sync", {7'h00, sync_found}, 8'h01);
	endtask
	// about 3300 clocks of work, so 25000 means a hang
	initial begin
		#100000;
		error_cnt++;
		results();
	end
	initial begin
		t_reset();
		t_ctrl();
		t_fill();
		t_rx();
		t_modem();
		t_sync();
		results();
	end
endmodule
`default_nettype wire
